// ==== logic/gdc_decade_counter.sv ====
/*
 * Gated decade counter: BCD count 0..9 with TTL-side and ECL-side carry.
 * Carries are one-cycle pulses on the wrap from nine back to zero.
 * Assumes pins synchronous to i_clk_sys; the count lines are read only
 * while the counting clock is stopped or inhibited.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gdc_regs.svh"

module gdc_decade_counter
	import gdc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Counting pins
	input wire logic i_count_clk,
	input wire logic i_count_inhibit,
	input wire logic i_count_reset,
	// Count and carries
	output logic [3:0] o_bcd,
	output logic o_carry_ttl,
	output logic o_carry_ecl
);

	// ----------------------------------------
	// Edge gating
	// ----------------------------------------
	logic advance;
	gdc_state_t state_reg;
	gdc_state_t state_next;

	gdc_edge_gate u_edge (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_count_clk(i_count_clk),
		.i_count_inhibit(i_count_inhibit),
		.o_advance(advance)
	);

	// Wrap test used for next count and carry
	function automatic logic at_last(input logic [3:0] c);
		at_last = (c == `GDC_COUNT_LAST);
	endfunction : at_last

	// ----------------------------------------
	// Count logic
	// ----------------------------------------
	// Reset pin first, then a counted edge
	always_comb begin
		state_next = state_reg;
		state_next.carry = 1'h0;
		if (i_count_reset) begin
			state_next.count = `GDC_COUNT_ZERO;
		end else if (advance) begin
			if (at_last(state_reg.count)) begin
				state_next.count = `GDC_COUNT_ZERO;
				state_next.carry = 1'h1;
			end else begin
				state_next.count = state_reg.count + `GDC_COUNT_STEP;
			end
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg.count <= `GDC_COUNT_ZERO;
			state_reg.carry <= 1'h0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign o_bcd = state_reg.count;
	assign o_carry_ttl = state_reg.carry;
	assign o_carry_ecl = state_reg.carry;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Counted edge while the count is at nine
	sequence s_wrap;
		advance && !i_count_reset && at_last(state_reg.count);
	endsequence

	// Counted edge while the count is below nine
	sequence s_step;
		advance && !i_count_reset && !at_last(state_reg.count);
	endsequence

	// Rising count clock, inhibit low, reset pin idle, count below nine
	sequence s_clk_step;
		$past(i_reset_n) && $rose(i_count_clk) && !i_count_inhibit && !i_count_reset &&
			!at_last(o_bcd);
	endsequence

	// Rising inhibit, count clock low, reset pin idle, count below nine
	sequence s_inh_step;
		$past(i_reset_n) && $rose(i_count_inhibit) && !i_count_clk && !i_count_reset &&
			!at_last(o_bcd);
	endsequence

	// Rising count clock while inhibit is high
	sequence s_clk_blocked;
		$rose(i_count_clk) && i_count_inhibit && !i_count_reset;
	endsequence

	// Rising inhibit while the count clock is high
	sequence s_inh_blocked;
		$rose(i_count_inhibit) && i_count_clk && !i_count_reset;
	endsequence

	// Inhibit high on this edge and the one before
	sequence s_inh_held;
		i_count_inhibit && $past(i_count_inhibit) && !i_count_reset;
	endsequence

	// Reset pin high on the same edge as a counted edge
	sequence s_reset_on_edge;
		i_count_reset && advance;
	endsequence

	// Count back at zero after a nonzero value
	sequence s_back_to_zero;
		o_bcd == `GDC_COUNT_ZERO && $past(o_bcd) != `GDC_COUNT_ZERO;
	endsequence

	// ----------------------------------------
	// Reset pin checks
	// ----------------------------------------
	// Reset pin clears count and carry on the next edge
	AST_RESET_ZERO: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_count_reset |=> o_bcd == `GDC_COUNT_ZERO && !o_carry_ttl)
		else $error("reset pin did not force zero");

	// Reset pin wins over a counted edge
	AST_RESET_WINS: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_reset_on_edge |=> o_bcd == `GDC_COUNT_ZERO && !o_carry_ecl)
		else $error("counted edge beat the reset pin");

	// Count returns to zero only by reset pin or wrap
	AST_BACK_TO_ZERO: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_back_to_zero |-> $past(i_count_reset) || $past(o_bcd) == `GDC_COUNT_LAST)
		else $error("count dropped to zero without wrap or reset");

	// ----------------------------------------
	// Counting checks
	// ----------------------------------------
	// Count stays a BCD digit
	AST_BCD_RANGE: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_bcd <= `GDC_COUNT_LAST)
		else $error("count left BCD range");

	// A counted edge below nine steps by one
	AST_STEP_ONE: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		advance && !i_count_reset && !at_last(o_bcd) |=> o_bcd == $past(o_bcd) + 4'h1)
		else $error("count did not step by one");

	// Clock edge with inhibit low steps the count
	AST_CLK_STEP: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_clk_step |=> o_bcd == $past(o_bcd) + `GDC_COUNT_STEP)
		else $error("clock edge did not step the count");

	// Inhibit edge with clock low steps the count
	AST_INH_STEP: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_inh_step |=> o_bcd == $past(o_bcd) + `GDC_COUNT_STEP)
		else $error("inhibit edge did not step the count");

	// No counted edge, no movement and no carry
	AST_HOLD: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		!advance && !i_count_reset |=> $stable(o_bcd) && !o_carry_ttl)
		else $error("count moved without a counted edge");

	// Clock edge under inhibit is ignored
	AST_CLK_BLOCKED: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_clk_blocked |=> $stable(o_bcd))
		else $error("clock edge counted while inhibited");

	// Inhibit edge with clock high is ignored
	AST_INH_BLOCKED: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_inh_blocked |=> $stable(o_bcd))
		else $error("inhibit edge counted with clock high");

	// Inhibit held high freezes the count
	AST_INH_HELD: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_inh_held |=> $stable(o_bcd))
		else $error("count moved while inhibit held high");

	// ----------------------------------------
	// Carry checks
	// ----------------------------------------
	// Wrap from nine gives zero and both carries
	AST_WRAP_CARRY: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_wrap |=> o_carry_ttl && o_carry_ecl && o_bcd == `GDC_COUNT_ZERO)
		else $error("wrap without carry");

	// Step below nine gives no carry
	AST_STEP_NO_CARRY: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		s_step |=> !o_carry_ttl && !o_carry_ecl)
		else $error("carry on a step below nine");

	// Carry only after a counted edge at nine
	AST_CARRY_ONLY_WRAP: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_carry_ttl |-> $past(advance) && $past(o_bcd) == `GDC_COUNT_LAST)
		else $error("carry without wrap");

	// Both carry outputs agree
	AST_CARRY_PAIR: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_carry_ttl == o_carry_ecl)
		else $error("carry outputs differ");

	// Carry lasts a single cycle
	AST_CARRY_PULSE: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_carry_ttl |=> !o_carry_ttl)
		else $error("carry longer than one cycle");

endmodule : gdc_decade_counter

`default_nettype wire

// ==== logic/gdc_edge_gate.sv ====
/*
 * Edge detector that turns clock and inhibit pin edges into count strobes.
 * Assumes both pins synchronous to i_clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gdc_regs.svh"

module gdc_edge_gate
	import gdc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Pins
	input wire logic i_count_clk,
	input wire logic i_count_inhibit,
	// Strobe
	output logic o_advance
);

	gdc_edge_t state_reg;
	gdc_edge_t state_next;

	// Next history is the present pin levels; armed after the first edge
	always_comb begin
		state_next.clk_in = i_count_clk;
		state_next.inh_in = i_count_inhibit;
		state_next.armed = 1'h1;
	end

	// History register
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg.clk_in <= `GDC_PIN_RESET;
			state_reg.inh_in <= `GDC_PIN_RESET;
			state_reg.armed <= `GDC_ARM_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Count on a rising edge of one input while the other is low; the first
	// edge after reset only loads the history, so a pin held high is no edge
	assign o_advance = state_reg.armed &&
		((i_count_clk && !state_reg.clk_in && !i_count_inhibit) ||
		(i_count_inhibit && !state_reg.inh_in && !i_count_clk));

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_INHIBIT_BLOCKS: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_count_inhibit && $past(i_count_inhibit) |-> !o_advance)
		else $error("advance while inhibit held high");
	AST_CLK_EDGE_COUNTS: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$past(i_reset_n) && $rose(i_count_clk) && !i_count_inhibit |-> o_advance)
		else $error("clock edge with inhibit low not counted");
	AST_INH_EDGE_COUNTS: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$past(i_reset_n) && $rose(i_count_inhibit) && !i_count_clk |-> o_advance)
		else $error("inhibit edge with clock low not counted");
	AST_NO_EDGE_NO_COUNT: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		!$rose(i_count_clk) && !$rose(i_count_inhibit) |-> !o_advance)
		else $error("advance without a rising edge");

endmodule : gdc_edge_gate

`default_nettype wire

// ==== logic/gdc_pkg.sv ====
/*
 * Types of the gated decade counter.
 * Assumes gdc_regs.svh on the include path.
 */
`default_nettype none
`include "gdc_regs.svh"

package gdc_pkg;
	// Registered state of the edge detector
	typedef struct packed {
		logic clk_in;
		logic inh_in;
		logic armed;
	} gdc_edge_t;

	// Registered state of the counter
	typedef struct packed {
		logic [3:0] count;
		logic carry;
	} gdc_state_t;
endpackage : gdc_pkg

`default_nettype wire

// ==== logic/gdc_regs.svh ====
/*
 * Constants of the gated decade counter: count limits, count step, input history reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
// Function
// - Divide the clock by ten and show the count as four-bit BCD.
// - Reset forces count 0000, ahead of clock and inhibit.
// - While inhibit is high, clock edges do not advance the count.
// - A rising edge of clock or inhibit counts while the other is low.
`ifndef GDC_REGS_SVH
`define GDC_REGS_SVH

// ----------------------------------------
// Count values
// ----------------------------------------
`define GDC_COUNT_ZERO 4'h0
`define GDC_COUNT_LAST 4'h9
`define GDC_COUNT_STEP 4'h1

// ----------------------------------------
// Input history reset values
// ----------------------------------------
`define GDC_PIN_RESET 1'h0
`define GDC_ARM_RESET 1'h0

`endif

// ==== tb/gated_decade_counter_tb_top.sv ====
/*
 * Bench of the gated decade counter: table of pin steps, then resets.
 * Assumes the design files and gdc_src_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module gated_decade_counter_tb_top;
	logic i_clk_sys = 1'h0;
	logic i_reset_n = 1'h0;
	logic pin_clk;
	logic pin_inh;
	logic pin_rst;
	logic [3:0] o_bcd;
	logic o_carry_ttl;
	logic o_carry_ecl;
	int error_cnt = 0;
	int checks_done = 0;
	// Rows: pins {reset, inhibit, clock}, then BCD, then carry
	logic [7:0] rows [0:30] = '{8'h22, 8'h02, 8'h24, 8'h04,
		8'h26, 8'h06, 8'h28, 8'h08, 8'h2A, 8'h0A, 8'h2C, 8'h0C, 8'h2E, 8'h0E,
		8'h30, 8'h10, 8'h32, 8'h12, 8'h41, 8'h60, 8'h40, 8'h00, 8'h22, 8'h62,
		8'h22, 8'h02, 8'h44, 8'h04, 8'hA0, 8'h20, 8'h00};

	// Clock, 20 ns period
	always #10 i_clk_sys = ~i_clk_sys;

	gdc_src_model src (.o_count_clk(pin_clk),
		.o_count_inhibit(pin_inh), .o_count_reset(pin_rst));

	gdc_decade_counter uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_count_clk(pin_clk), .i_count_inhibit(pin_inh), .i_count_reset(pin_rst),
		.o_bcd(o_bcd), .o_carry_ttl(o_carry_ttl), .o_carry_ecl(o_carry_ecl));

	task automatic chk_bcd(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t bcd got %h exp %h", $time, got, exp);
		end
	endtask : chk_bcd

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t carry got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// Watchdog, about six times the expected run
	initial begin
		#5000;
		error_cnt++;
		end_sim();
	end

	// Table, then reset cases
	initial begin
		repeat (3) @(negedge i_clk_sys);
		i_reset_n = 1'h1;
		// First edge after release only arms the edge history
		@(negedge i_clk_sys);
		foreach (rows[i]) begin
			src.drive(rows[i][7:5]);
			@(negedge i_clk_sys);
			chk_bcd(o_bcd, rows[i][4:1]);
			chk_bit(o_carry_ttl, rows[i][0]);
			chk_bit(o_carry_ecl, rows[i][0]);
		end
		$display("Table test done");
		src.drive(3'h1);
		@(negedge i_clk_sys);
		chk_bcd(o_bcd, 4'h1);
		// Async reset clears without a clock edge
		i_reset_n = 1'h0;
		#1;
		chk_bcd(o_bcd, 4'h0);
		// Count clock stays high across release: no false edge
		@(negedge i_clk_sys);
		i_reset_n = 1'h1;
		@(negedge i_clk_sys);
		chk_bcd(o_bcd, 4'h0);
		src.drive(3'h0);
		@(negedge i_clk_sys);
		src.drive(3'h1);
		@(negedge i_clk_sys);
		chk_bcd(o_bcd, 4'h1);
		$display("Reset test done");
		end_sim();
	end
endmodule : gated_decade_counter_tb_top

`default_nettype wire

// ==== tb/gdc_src_model.sv ====
/*
 * Source model: drives the count clock, inhibit and reset pins.
 * Assumes the bench calls drive at the falling edge of i_clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module gdc_src_model (
	// Pins
	output logic o_count_clk,
	output logic o_count_inhibit,
	output logic o_count_reset
);
	// Pins low at start, so release of reset sees no edge
	initial begin
		o_count_clk = 1'h0;
		o_count_inhibit = 1'h0;
		o_count_reset = 1'h0;
	end

	// Pins hold between calls, so count lines are read with the clock still
	task automatic drive(input logic [2:0] v);
		{o_count_reset, o_count_inhibit, o_count_clk} = v;
	endtask : drive
endmodule : gdc_src_model

`default_nettype wire
